/* dv/fspd_ctrl_bench.sv */
`timescale 1ns/10ps
module fspd_ctrl_bench
    import fspd_pkg::*;
();
    logic i_clk_sys = 1'b0;
    logic i_nrst = 1'b0;
    logic i_req_valid = 1'b0;
    fspd_req_t i_req = '0;
    logic i_quad_en = 1'b0;
    logic write_in_progress_flag = 1'b0;
    logic o_req_ready, o_done, o_sck, o_cs_n, o_qpi, o_crm, o_dpd, o_ers_blk;
    fspd_rsp_t o_rsp;
    logic [3:0] o_io, o_io_oe_n, m_io, io_w;
    logic [7:0] m_op;
    int fail_count = 0;
    int n_compared = 0;
    int fcnt = 0;
    localparam int SUS_WAIT = 20;
    assign io_w = (~o_io_oe_n & o_io) | (o_io_oe_n & m_io);
    always #2.5 i_clk_sys = ~i_clk_sys;
    always @(posedge o_sck)
        if (o_io_oe_n === 4'h0 && o_io === 4'hf)
            fcnt++;
    fspd_ctrl #(.ERS_SUS_WAIT_CYC(SUS_WAIT), .ERS_GAP_WAIT_CYC(50)) fspd_ctrl_inst (
        .i_clk_sys(i_clk_sys), .i_nrst(i_nrst), .i_req_valid(i_req_valid), .i_req(i_req),
        .i_quad_en(i_quad_en), .i_io(io_w), .o_req_ready(o_req_ready), .o_done(o_done),
        .o_rsp(o_rsp), .o_sck(o_sck), .o_cs_n(o_cs_n), .o_io(o_io), .o_io_oe_n(o_io_oe_n),
        .o_qpi(o_qpi), .o_crm(o_crm), .o_dpd(o_dpd), .o_ers_blk(o_ers_blk));
    fspd_flash_model fspd_flash_model_inst (.i_sck(o_sck), .i_cs_n(o_cs_n), .i_io(io_w),
        .i_wip(write_in_progress_flag), .o_io(m_io), .o_op(m_op));
    task automatic wrap_up();
        if (fail_count == 0 && n_compared > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("unexpected at %0t: saw %h, expected %h", $time, seen, exp);
        end
    endtask
    // Entered and left one time unit after a rising edge
    task automatic send(input fspd_cmd_t op, input logic k, input logic a4, output int n);
        i_req = '{op, 24'h001230, k, a4};
        i_req_valid = 1'b1;
        while (o_req_ready !== 1'b1) @(posedge i_clk_sys) #1;
        @(posedge i_clk_sys) #1;
        i_req_valid = 1'b0;
        n = 0;
        while (o_done !== 1'b1 && n < 4000)
        begin
            @(posedge i_clk_sys) #1;
            n++;
        end
        chk(n < 4000, 1);
    endtask
    task automatic t_suspend();
        int n;
        int n0;
        send(CMD_PGM_SUS, 0, 0, n);
        n0 = n;
        chk(m_op, OP_SUSPEND);
        send(CMD_PGM_RES, 0, 0, n);
        chk(m_op, OP_RESUME);
        send(CMD_ERS_SUS, 0, 0, n);
        chk(m_op, OP_SUSPEND);
        chk(n, n0 + SUS_WAIT);
        write_in_progress_flag = 1'b1;
        send(CMD_POLL, 0, 0, n);
        chk(o_rsp, {2'b01, 8'h5b});
        write_in_progress_flag = 1'b0;
        send(CMD_POLL, 0, 0, n);
        chk(o_rsp, {2'b00, 8'h5a});
    endtask
    task automatic t_erase();
        int n;
        send(CMD_ERS_RES, 0, 0, n);
        chk(m_op, OP_RESUME);
        chk(o_ers_blk, 1);
        send(CMD_ERS_SUS, 0, 0, n);
        chk(o_rsp.refused, 1);
        chk(m_op, OP_RESUME);
        repeat (60) @(posedge i_clk_sys);
        #1;
        send(CMD_ERS_SUS, 0, 0, n);
        chk(m_op, OP_SUSPEND);
    endtask
    task automatic t_power();
        int n;
        int n0;
        send(CMD_DPD_ENTER, 0, 0, n);
        n0 = n;
        chk(m_op, OP_PD_ENTER);
        chk(o_dpd, 1);
        send(CMD_PGM_SUS, 0, 0, n);
        chk({o_rsp.refused, m_op}, {1'b1, OP_PD_ENTER});
        send(CMD_DPD_REL, 0, 0, n);
        chk({o_dpd, m_op}, {1'b0, OP_PD_RELEASE});
        chk(n, n0 + PD_REL_CYC);
    endtask
    task automatic t_quad();
        int n;
        send(CMD_QPI_ENTER, 0, 0, n);
        chk({o_rsp.refused, o_qpi}, 2'b10);
        i_quad_en = 1'b1;
        send(CMD_QPI_ENTER, 0, 0, n);
        chk({o_qpi, m_op}, {1'b1, OP_QPI_ENTER});
        send(CMD_PGM_SUS, 0, 0, n);
        chk(m_op, OP_SUSPEND);
        send(CMD_QPI_EXIT, 0, 0, n);
        chk({o_qpi, m_op}, {1'b0, OP_QPI_EXIT});
        send(CMD_QPI_ENTER, 0, 0, n);
        send(CMD_QPI_RESET, 0, 0, n);
        chk({o_qpi, m_op}, {1'b0, OP_RST});
    endtask
    task automatic t_cont();
        int n;
        i_quad_en = 1'b0;
        send(CMD_QREAD, 1, 0, n);
        chk(o_rsp.refused, 1);
        i_quad_en = 1'b1;
        send(CMD_QREAD, 1, 0, n);
        chk({o_crm, m_op}, {1'b1, OP_QREAD});
        send(CMD_PGM_SUS, 0, 0, n);
        chk(o_rsp.refused, 1);
        send(CMD_QREAD, 0, 0, n);
        chk(o_crm, 0);
        for (int a = 0; a < 2; a++)
        begin
            send(CMD_QREAD, 1, 0, n);
            fcnt = 0;
            send(CMD_CRM_EXIT, 0, a[0], n);
            chk({o_crm, 8'(fcnt)}, {1'b0, (a == 1) ? 8'h0a : 8'h08});
        end
    endtask
    initial
    begin
        repeat (2) @(posedge i_clk_sys);
        #1;
        i_nrst = 1'b1;
        repeat (2) @(posedge i_clk_sys);
        #1;
        t_suspend();
        t_erase();
        t_power();
        t_quad();
        t_cont();
        wrap_up();
    end
    initial
    begin
        #100000;
        fail_count++;
        wrap_up();
    end
endmodule // fspd_ctrl_bench

/* dv/fspd_ctrl_checker.sv */
`timescale 1ns/10ps
module fspd_ctrl_checker
    import fspd_pkg::*;
#(
    parameter int unsigned ERS_SUS_WAIT_CYC = 20
)
(
    input wire logic i_clk_sys,
    input wire logic i_nrst,
    input wire logic i_req_valid,
    input wire fspd_req_t i_req,
    input wire logic i_quad_en,
    input wire logic o_req_ready,
    input wire logic o_done,
    input wire fspd_rsp_t o_rsp,
    input wire logic o_cs_n,
    input wire logic o_qpi,
    input wire logic o_crm,
    input wire logic o_dpd,
    input wire logic o_ers_blk
);
    logic [10:0] cnt;
    fspd_req_t last;
    always_ff @(posedge i_clk_sys)
    begin
        if (!i_nrst || (i_req_valid && o_req_ready))
            cnt <= 11'h000;
        else if (cnt != 11'h7ff)
            cnt <= cnt + 11'h001;
    end
    always_ff @(posedge i_clk_sys)
    begin
        if (i_req_valid && o_req_ready)
            last <= i_req;
    end
    default clocking @(posedge i_clk_sys); endclocking
    default disable iff (!i_nrst);
    sequence s_take;
        i_req_valid && o_req_ready;
    endsequence
    sequence s_ok;
        o_done && !o_rsp.refused;
    endsequence
    sequence s_refused;
        o_done && o_rsp.refused && o_cs_n;
    endsequence
    a_dpd_refuse: assert property (s_take ##0 (o_dpd && i_req.op != CMD_DPD_REL)
        |=> s_refused) else $error("command not refused in power-down");
    a_qe_refuse: assert property (s_take ##0 (!i_quad_en &&
        (i_req.op == CMD_QPI_ENTER || i_req.op == CMD_QREAD)) |=> s_refused)
        else $error("quad command not refused without quad enable");
    a_crm_refuse: assert property (s_take ##0 (o_crm && i_req.op != CMD_QREAD &&
        i_req.op != CMD_CRM_EXIT) |=> s_refused) else $error("op accepted in cont read");
    a_sus_wait: assert property (s_ok ##0 (last.op == CMD_ERS_SUS)
        |-> int'(cnt) > ERS_SUS_WAIT_CYC) else $error("suspend latency cut short");
    a_rel_wait: assert property (s_ok ##0 (last.op == CMD_DPD_REL)
        |-> cnt > 11'h258 && !o_dpd) else $error("release wait cut short");
    a_dpd_enter: assert property (s_ok ##0 (last.op == CMD_DPD_ENTER) |-> o_dpd)
        else $error("power-down not tracked");
    a_qpi_enter: assert property (s_ok ##0 (last.op == CMD_QPI_ENTER) |-> o_qpi)
        else $error("four-wire mode not entered");
    a_qpi_leave: assert property (s_ok ##0 (last.op inside {CMD_QPI_EXIT, CMD_QPI_RESET})
        |-> !o_qpi) else $error("four-wire mode not left");
    a_crm_track: assert property (s_ok ##0 (last.op == CMD_QREAD)
        |-> o_crm == last.keep) else $error("cont read mode mistracked");
    a_crm_exit: assert property (s_ok ##0 (last.op == CMD_CRM_EXIT) |-> !o_crm)
        else $error("forced exit left cont read on");
    a_gap_block: assert property (s_ok ##0 (last.op == CMD_ERS_RES) |-> o_ers_blk)
        else $error("suspend hold-off missing");
    a_poll_wip: assert property (s_ok ##0 (last.op == CMD_POLL)
        |-> o_rsp.write_in_progress_flag == o_rsp.data[0]) else $error("busy flag not status bit 0");
endmodule // fspd_ctrl_checker
bind fspd_ctrl fspd_ctrl_checker #(.ERS_SUS_WAIT_CYC(ERS_SUS_WAIT_CYC)) fspd_ctrl_checker_inst (
    .i_clk_sys, .i_nrst, .i_req_valid, .i_req, .i_quad_en, .o_req_ready, .o_done,
    .o_rsp, .o_cs_n, .o_qpi, .o_crm, .o_dpd, .o_ers_blk);

/* dv/fspd_flash_model.sv */
`timescale 1ns/10ps
module fspd_flash_model
    import fspd_pkg::*;
(
    input wire logic i_sck,
    input wire logic i_cs_n,
    input wire logic [3:0] i_io,
    input wire logic i_wip,
    output logic [3:0] o_io,
    output logic [7:0] o_op
);
    logic [7:0] sr = 8'h00;
    logic [7:0] st = 8'h00;
    logic qpi = 1'b0;
    logic dpd = 1'b0;
    int n = 0;
    initial o_io = 4'h5;
    initial o_op = 8'h00;
    always @(negedge i_cs_n) n = 0;
    // Released lines flip so stale data never looks valid
    always @(posedge i_cs_n) o_io = ~o_io;
    always @(negedge i_sck)
        if (!i_cs_n)
        begin
            o_io[1] = st[7];
            st = {st[6:0], ~st[7]};
        end
    always @(posedge i_sck)
        if (!i_cs_n && n < 8)
        begin
            sr = qpi ? {sr[3:0], i_io} : {sr[6:0], i_io[0]};
            n = n + (qpi ? 4 : 1);
            if (n == 8 && (!dpd || sr == OP_PD_RELEASE))
            begin
                o_op = sr;
                st = {7'h2d, i_wip};
                dpd = (sr == OP_PD_ENTER);
                if (sr == OP_QPI_ENTER)
                    qpi = 1'b1;
                if (sr == OP_QPI_EXIT || sr == OP_RST)
                    qpi = 1'b0;
            end
        end
endmodule // fspd_flash_model

/* rtl/fspd_ctrl.sv */
`timescale 1ns/10ps
module fspd_ctrl
    import fspd_pkg::*;
#(
    parameter int unsigned ERS_SUS_WAIT_CYC = ERS_SUS_LAT_CYC,
    parameter int unsigned ERS_GAP_WAIT_CYC = ERS_GAP_CYC
)
(
    input wire logic i_clk_sys,
    input wire logic i_nrst,
    input wire logic i_req_valid,
    input wire fspd_req_t i_req,
    input wire logic i_quad_en,
    input wire logic [3:0] i_io,
    output logic o_req_ready,
    output logic o_done,
    output fspd_rsp_t o_rsp,
    output logic o_sck,
    output logic o_cs_n,
    output logic [3:0] o_io,
    output logic [3:0] o_io_oe_n,
    output logic o_qpi,
    output logic o_crm,
    output logic o_dpd,
    output logic o_ers_blk
);

    localparam logic [7:0] DIV_TOP = 8'(SCK_HALF_CYC - 1);

    fspd_st_t st;
    fspd_st_t next_st;
    fspd_req_t cur;
    logic [31:0] sr;
    logic [31:0] next_sr;
    logic [3:0] cnt;
    logic [3:0] next_cnt;
    logic [7:0] div;
    logic pend_rst;
    logic [31:0] wait_cnt;
    logic [31:0] gap_cnt;
    logic [3:0] io_m;
    logic [3:0] io_s;

    function automatic logic [7:0] opcode_of(input fspd_cmd_t c);
        unique case (c)
            CMD_PGM_SUS: opcode_of = OP_SUSPEND;
            CMD_ERS_SUS: opcode_of = OP_SUSPEND;
            CMD_PGM_RES: opcode_of = OP_RESUME;
            CMD_ERS_RES: opcode_of = OP_RESUME;
            CMD_POLL: opcode_of = OP_RD_STATUS;
            CMD_DPD_ENTER: opcode_of = OP_PD_ENTER;
            CMD_DPD_REL: opcode_of = OP_PD_RELEASE;
            CMD_QPI_ENTER: opcode_of = OP_QPI_ENTER;
            CMD_QPI_EXIT: opcode_of = OP_QPI_EXIT;
            CMD_QPI_RESET: opcode_of = OP_RST_EN;
            CMD_QREAD: opcode_of = OP_QREAD;
            default: opcode_of = OP_QPI_EXIT;
        endcase
    endfunction

    function automatic logic quad_of(input fspd_st_t p, input fspd_cmd_t c, input logic q);
        unique case (p)
            ST_OP: quad_of = q;
            ST_RD: quad_of = q || (c == CMD_QREAD);
            ST_AM, ST_DUM, ST_FX: quad_of = 1'b1;
            default: quad_of = 1'b0;
        endcase
    endfunction

    function automatic logic [3:0] clks_of(input fspd_st_t p, input logic q, input logic a4);
        unique case (p)
            ST_OP: clks_of = q ? OP_CLK_4 : OP_CLK_1;
            ST_AM: clks_of = AM_CLK;
            ST_DUM: clks_of = DUM_CLK;
            ST_RD: clks_of = q ? RD_CLK_4 : RD_CLK_1;
            ST_FX: clks_of = a4 ? FX_CLK_4B : FX_CLK_3B;
            default: clks_of = 4'h0;
        endcase
    endfunction

    function automatic logic [31:0] load_of(input fspd_st_t p, input fspd_req_t r);
        unique case (p)
            ST_OP: load_of = {opcode_of(r.op), 24'h0};
            ST_AM: load_of = {r.addr, r.keep ? MODE_CONT : MODE_END};
            ST_FX: load_of = '1;
            default: load_of = 32'h0;
        endcase
    endfunction

    wire fspd_cmd_t act_op = (st == ST_IDLE) ? i_req.op : cur.op;
    wire shifting = (st == ST_OP) || (st == ST_AM) || (st == ST_DUM) || (st == ST_RD) ||
        (st == ST_FX);
    wire half_en = (div == DIV_TOP);
    wire rise = half_en && !o_sck && shifting;
    wire fall = half_en && o_sck && shifting;
    wire last = fall && (cnt == 4'h1);
    wire quad = quad_of(st, cur.op, o_qpi);
    wire accept = (st == ST_IDLE) && i_req_valid;
    wire q_en_req = (i_req.op == CMD_QPI_ENTER) || (i_req.op == CMD_QREAD);
    wire crm_ok = (i_req.op == CMD_QREAD) || (i_req.op == CMD_CRM_EXIT);
    // Device ignores these anyway; refusing keeps host state honest
    wire refuse = (o_dpd && (i_req.op != CMD_DPD_REL))
        || (o_crm && !crm_ok)
        || ((i_req.op == CMD_ERS_SUS) && (gap_cnt != 32'h0))
        || (!i_quad_en && q_en_req);
    wire fspd_st_t start_ph = (i_req.op == CMD_CRM_EXIT) ? ST_FX :
        ((i_req.op == CMD_QREAD) && o_crm) ? ST_AM : ST_OP;
    wire fspd_st_t ph_after = (st == ST_OP) ?
        ((cur.op == CMD_QREAD) ? ST_AM : (cur.op == CMD_POLL) ? ST_RD : ST_GAP) :
        (st == ST_AM) ? ST_DUM : (st == ST_DUM) ? ST_RD : ST_GAP;
    wire frame_end = (st == ST_GAP) && half_en && !pend_rst;
    wire [31:0] wait_load = (cur.op == CMD_ERS_SUS) ? ERS_SUS_WAIT_CYC :
        (cur.op == CMD_DPD_REL) ? 32'(PD_REL_CYC) : 32'h0;
    wire next_q = quad_of(next_st, act_op, o_qpi);
    wire drive = (next_st == ST_OP) || (next_st == ST_AM) || (next_st == ST_FX);
    wire next_shift = drive || (next_st == ST_DUM) || (next_st == ST_RD);

    always_comb
    begin
        next_st = st;
        next_sr = sr;
        next_cnt = cnt;
        unique case (st)
            ST_IDLE:
            begin
                if (accept && !refuse)
                begin
                    next_st = start_ph;
                    next_sr = load_of(start_ph, i_req);
                    next_cnt = clks_of(start_ph, quad_of(start_ph, i_req.op, o_qpi),
                        i_req.addr4);
                end
            end
            ST_OP, ST_AM, ST_DUM, ST_RD, ST_FX:
            begin
                if (rise && (st == ST_RD))
                begin
                    next_sr = quad ? {sr[27:0], io_s} : {sr[30:0], io_s[SO_LANE]};
                end
                if (fall)
                begin
                    if (st != ST_RD)
                    begin
                        // Forced exit keeps Fh up for 10 clocks with 4-byte addresses, 8 with 3-byte
                        next_sr = quad ? {sr[27:0], (st == ST_FX) ? 4'hf : 4'h0} :
                            {sr[30:0], 1'b0};
                    end
                    next_cnt = cnt - 4'h1;
                    if (cnt == 4'h1)
                    begin
                        next_st = ph_after;
                        if (ph_after != ST_GAP)
                        begin
                            next_sr = load_of(ph_after, cur);
                            next_cnt = clks_of(ph_after, quad_of(ph_after, cur.op, o_qpi),
                                cur.addr4);
                        end
                    end
                end
            end
            ST_GAP:
            begin
                if (half_en && pend_rst)
                begin
                    next_st = ST_OP;
                    next_sr = {OP_RST, 24'h0};
                    next_cnt = clks_of(ST_OP, o_qpi, cur.addr4);
                end
                else if (half_en)
                begin
                    next_st = (wait_load != 32'h0) ? ST_WAIT : ST_IDLE;
                end
            end
            ST_WAIT:
            begin
                if (wait_cnt == 32'h1)
                begin
                    next_st = ST_IDLE;
                end
            end
        endcase
    end

    // Pins are asynchronous to our clock
    always_ff @(posedge i_clk_sys)
    begin
        io_m <= i_io;
        io_s <= io_m;
    end

    always_ff @(posedge i_clk_sys)
    begin
        if (!i_nrst)
        begin
            st <= ST_IDLE;
            sr <= 32'h0;
            cnt <= 4'h0;
            div <= 8'h0;
        end
        else
        begin
            st <= next_st;
            sr <= next_sr;
            cnt <= next_cnt;
            div <= (half_en || !(shifting || st == ST_GAP)) ? 8'h0 : div + 8'h1;
        end
    end

    // Pin drive registered from next state to keep outputs glitch free
    always_ff @(posedge i_clk_sys)
    begin
        if (!i_nrst)
        begin
            o_sck <= 1'b0;
            o_cs_n <= 1'b1;
            o_io <= 4'h0;
            o_io_oe_n <= OE_NONE;
            o_req_ready <= 1'b0;
        end
        else
        begin
            // No rise on the edge that opens a frame, even straight out of the gap
            o_sck <= next_shift && (rise || (o_sck && !fall));
            o_cs_n <= !next_shift;
            o_io <= next_q ? next_sr[31:28] : {3'h0, next_sr[31]};
            o_io_oe_n <= !drive ? OE_NONE : next_q ? OE_ALL : OE_IO0;
            o_req_ready <= (next_st == ST_IDLE);
        end
    end

    always_ff @(posedge i_clk_sys)
    begin
        if (!i_nrst)
        begin
            cur <= '0;
            pend_rst <= 1'b0;
        end
        else if (accept && !refuse)
        begin
            cur <= i_req;
            pend_rst <= (i_req.op == CMD_QPI_RESET);
        end
        else if ((st == ST_GAP) && half_en)
        begin
            pend_rst <= 1'b0;
        end
    end

    // Mode tracking follows what the device believes after each frame
    always_ff @(posedge i_clk_sys)
    begin
        if (!i_nrst)
        begin
            o_qpi <= 1'b0;
            o_crm <= 1'b0;
            o_dpd <= 1'b0;
        end
        else if (frame_end)
        begin
            unique case (cur.op)
                CMD_QPI_ENTER: o_qpi <= 1'b1;
                CMD_QPI_EXIT: o_qpi <= 1'b0;
                CMD_QPI_RESET:
                begin
                    o_qpi <= 1'b0;
                    o_crm <= 1'b0;
                end
                CMD_DPD_ENTER: o_dpd <= 1'b1;
                CMD_DPD_REL: o_dpd <= 1'b0;
                CMD_QREAD: o_crm <= cur.keep;
                CMD_CRM_EXIT: o_crm <= 1'b0;
                default: o_dpd <= o_dpd;
            endcase
        end
    end

    always_ff @(posedge i_clk_sys)
    begin
        if (!i_nrst)
        begin
            wait_cnt <= 32'h0;
            gap_cnt <= 32'h0;
            o_ers_blk <= 1'b0;
        end
        else
        begin
            if (frame_end)
            begin
                wait_cnt <= wait_load;
            end
            else if (st == ST_WAIT)
            begin
                wait_cnt <= wait_cnt - 32'h1;
            end
            if (frame_end && (cur.op == CMD_ERS_RES))
            begin
                gap_cnt <= ERS_GAP_WAIT_CYC;
            end
            else if (gap_cnt != 32'h0)
            begin
                gap_cnt <= gap_cnt - 32'h1;
            end
            o_ers_blk <= (frame_end && (cur.op == CMD_ERS_RES)) || (gap_cnt > 32'h1);
        end
    end

    always_ff @(posedge i_clk_sys)
    begin
        if (!i_nrst)
        begin
            o_done <= 1'b0;
            o_rsp <= '0;
        end
        else
        begin
            o_done <= (accept && refuse) ||
                ((st != ST_IDLE) && (next_st == ST_IDLE));
            if (accept)
            begin
                o_rsp.refused <= refuse;
            end
            if (last && (st == ST_RD))
            begin
                o_rsp.data <= sr[7:0];
                o_rsp.write_in_progress_flag <= sr[WIP_BIT];
            end
        end
    end

endmodule // fspd_ctrl

/* rtl/fspd_pkg.sv */
package fspd_pkg;
    localparam int CLK_NS = 5;
    localparam int UNIT_1US_NS = 1000;
    localparam int UNIT_64US_NS = 64000;
    localparam logic [4:0] ERS_SUS_CNT = 5'b10101;
    localparam logic [3:0] ERS_GAP_CNT = 4'b1111;
    localparam logic [4:0] PD_REL_CNT = 5'b00010;
    localparam int ERS_SUS_LAT_NS = (int'(ERS_SUS_CNT) + 1) * UNIT_1US_NS;
    localparam int ERS_SUS_LAT_CYC = ERS_SUS_LAT_NS / CLK_NS;
    localparam int ERS_GAP_NS = (int'(ERS_GAP_CNT) + 1) * UNIT_64US_NS;
    localparam int ERS_GAP_CYC = (ERS_GAP_NS + CLK_NS - 1) / CLK_NS;
    localparam int PD_REL_NS = (int'(PD_REL_CNT) + 1) * UNIT_1US_NS;
    localparam int PD_REL_CYC = PD_REL_NS / CLK_NS;
    localparam int SCK_HALF_NS = 20;
    localparam int SCK_HALF_CYC = (SCK_HALF_NS / CLK_NS < 1) ? 1 : SCK_HALF_NS / CLK_NS;
    localparam logic [7:0] OP_SUSPEND = 8'h75;
    localparam logic [7:0] OP_RESUME = 8'h7a;
    localparam logic [7:0] OP_RD_STATUS = 8'h05;
    localparam logic [7:0] OP_PD_RELEASE = 8'hab;
    localparam logic [7:0] OP_PD_ENTER = 8'hb9;
    localparam logic [7:0] OP_QPI_ENTER = 8'h38;
    localparam logic [7:0] OP_QPI_EXIT = 8'hff;
    localparam logic [7:0] OP_RST_EN = 8'h66;
    localparam logic [7:0] OP_RST = 8'h99;
    localparam logic [7:0] OP_QREAD = 8'heb;
    localparam logic [7:0] MODE_CONT = 8'ha5;
    localparam logic [7:0] MODE_END = 8'h00;
    localparam logic [3:0] OP_CLK_1 = 4'h8;
    localparam logic [3:0] OP_CLK_4 = 4'h2;
    localparam logic [3:0] AM_CLK = 4'h8;
    localparam logic [3:0] DUM_CLK = 4'h4;
    localparam logic [3:0] RD_CLK_1 = 4'h8;
    localparam logic [3:0] RD_CLK_4 = 4'h2;
    localparam logic [3:0] FX_CLK_3B = 4'h8;
    localparam logic [3:0] FX_CLK_4B = 4'ha;
    localparam logic [3:0] OE_NONE = 4'hf;
    localparam logic [3:0] OE_IO0 = 4'he;
    localparam logic [3:0] OE_ALL = 4'h0;
    localparam int WIP_BIT = 0;
    localparam int SO_LANE = 1;

    typedef enum logic [3:0] {
        CMD_PGM_SUS, CMD_PGM_RES, CMD_ERS_SUS, CMD_ERS_RES, CMD_POLL, CMD_DPD_ENTER,
        CMD_DPD_REL, CMD_QPI_ENTER, CMD_QPI_EXIT, CMD_QPI_RESET, CMD_QREAD, CMD_CRM_EXIT
    } fspd_cmd_t;

    typedef enum logic [2:0] {
        ST_IDLE, ST_OP, ST_AM, ST_DUM, ST_RD, ST_FX, ST_GAP, ST_WAIT
    } fspd_st_t;

    typedef struct packed {
        fspd_cmd_t op;
        logic [23:0] addr;
        logic keep;
        logic addr4;
    } fspd_req_t;

    typedef struct packed {
        logic refused;
        logic write_in_progress_flag;
        logic [7:0] data;
    } fspd_rsp_t;
endpackage
